// ---- design/spoof_frame_pkg.sv ----
// constants for spoof frame timing and buffer sram test access
// assumes a decoded 8-bit register address and 16-bit register data
package spoof_frame_pkg;
  localparam logic [7:0]  OFS_LINE_WIDTH      = 8'h10;
  localparam logic [7:0]  OFS_FRAME_HEIGHT    = 8'h11;
  localparam logic [7:0]  OFS_LEAD_TRAIL      = 8'h12;
  localparam logic [7:0]  OFS_RAM_TEST_CTRL   = 8'h1d;
  localparam logic [7:0]  OFS_INDIRECT_DATA   = 8'h1f;

  localparam logic [11:0] RST_LINE_WIDTH      = 12'h640;
  localparam logic [11:0] RST_FRAME_HEIGHT    = 12'h258;
  localparam logic [15:0] RST_LEAD_TRAIL      = 16'h0606;
  localparam logic [15:0] RST_RAM_TEST_CTRL   = 16'h0000;
  localparam logic [15:0] RST_INDIRECT_DATA   = 16'h0000;

  // field positions
  localparam int LEAD_LSB      = 0;
  localparam int TRAIL_LSB     = 8;
  localparam int RAM_ADDR_LSB  = 0;
  localparam int RAM_IDX_LSB   = 10;
  localparam int RAM_BANK_BIT  = 13;
  localparam int RAM_WE_BIT    = 15;

  localparam logic [9:0]  RAM_LAST_WORD       = 10'h31f;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_LINE  = 2'b10,
    ST_TRAIL = 2'b11
  } spoof_state_t;
endpackage : spoof_frame_pkg

// ---- design/spoof_frame_timing_sram_test.sv ----
// spoof frame generator around output fifo data, plus buffer sram test access
// assumes a register port decoded by the serial interface on ref_clk, a
// one-cycle pixel clock enable from the output clock divider, and srams that
// return read data one cycle after the read strobe
`timescale 1ns/1ns

// Summary of operation
// - each frame strobe holds exactly the programmed height of line strobes, reset 0x0258
// - wait lead field clocks, at least one, bits 7:0, before raising line strobe
// - wait trail field clocks, at least one, bits 15:8, after dropping line strobe
// - tested sram word address is bits 9:0, valid range 0 to 799
// - tested address advances only on test data accesses that strobe the sram: writes with write enable set, reads with it clear and no register write
// - bits 12:10 pick one of eight srams in the bank, 000 first
// - bit 13 picks bank: 1 luminance, 0 chrominance
// - each line strobe carries the programmed width in data bytes, reset 0x0640
// - write enable set writes data word to the one sram picked by bits 13:10, clear reads back
module spoof_frame_timing_sram_test #(
  parameter int DATA_W = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [15:0]       reg_rdata,
  input  wire logic              spoof_enable,
  input  wire logic              pix_clk_en,
  input  wire logic [DATA_W-1:0] fifo_data,
  input  wire logic              fifo_valid,
  output logic                   fifo_ready,
  output logic                   frame_valid,
  output logic                   line_valid,
  output logic      [DATA_W-1:0] pix_data,
  output logic                   pix_data_valid,
  output logic      [9:0]        ram_addr,
  output logic      [2:0]        ram_index,
  output logic                   ram_bank_luma,
  output logic      [15:0]       ram_wdata,
  output logic                   ram_we,
  output logic                   ram_re,
  input  wire logic [15:0]       ram_rdata
);
  logic        rst_meta_q;
  logic        rst_sync_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // register file
  logic [11:0] width_q,  width_d;
  logic [11:0] height_q, height_d;
  logic [15:0] lt_q,     lt_d;
  logic [15:0] ctrl_q,   ctrl_d;
  logic [15:0] word_q,   word_d;
  logic [15:0] rdata_q,  rdata_d;
  logic        we_q,     we_d;
  logic        re_q,     re_d;
  logic        load_q,   load_d;

  function automatic logic [9:0] next_word_addr(input logic [9:0] a);
    next_word_addr = (a >= spoof_frame_pkg::RAM_LAST_WORD) ? 10'h000 : a + 10'h001;
  endfunction : next_word_addr

  always_comb begin
    width_d  = width_q;
    height_d = height_q;
    lt_d     = lt_q;
    ctrl_d   = ctrl_q;
    word_d   = word_q;
    rdata_d  = rdata_q;
    we_d     = 1'b0;
    re_d     = 1'b0;
    load_d   = re_q;
    if (reg_wr) begin
      case (reg_addr)
        spoof_frame_pkg::OFS_LINE_WIDTH:    width_d  = reg_wdata[11:0];
        spoof_frame_pkg::OFS_FRAME_HEIGHT:  height_d = reg_wdata[11:0];
        spoof_frame_pkg::OFS_LEAD_TRAIL:    lt_d     = reg_wdata;
        spoof_frame_pkg::OFS_RAM_TEST_CTRL: ctrl_d   = reg_wdata;
        spoof_frame_pkg::OFS_INDIRECT_DATA: begin
          word_d = reg_wdata;
          if (ctrl_q[spoof_frame_pkg::RAM_WE_BIT]) begin
            we_d = 1'b1;
            ctrl_d[9:0] = next_word_addr(ctrl_q[9:0]);
          end
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        spoof_frame_pkg::OFS_LINE_WIDTH:    rdata_d = {4'h0, width_q};
        spoof_frame_pkg::OFS_FRAME_HEIGHT:  rdata_d = {4'h0, height_q};
        spoof_frame_pkg::OFS_LEAD_TRAIL:    rdata_d = lt_q;
        spoof_frame_pkg::OFS_RAM_TEST_CTRL: rdata_d = ctrl_q;
        spoof_frame_pkg::OFS_INDIRECT_DATA: begin
          rdata_d = word_q;
          if (!ctrl_q[spoof_frame_pkg::RAM_WE_BIT] && !reg_wr) begin
            re_d = 1'b1;
            ctrl_d[9:0] = next_word_addr(ctrl_q[9:0]);
          end
        end
        default: rdata_d = 16'h0000;
      endcase
    end
    // returning test read data wins over a software write in the same cycle
    if (load_q) begin
      word_d = ram_rdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      width_q  <= spoof_frame_pkg::RST_LINE_WIDTH;
      height_q <= spoof_frame_pkg::RST_FRAME_HEIGHT;
      lt_q     <= spoof_frame_pkg::RST_LEAD_TRAIL;
      ctrl_q   <= spoof_frame_pkg::RST_RAM_TEST_CTRL;
      word_q   <= spoof_frame_pkg::RST_INDIRECT_DATA;
      rdata_q  <= 16'h0000;
      we_q     <= 1'b0;
      re_q     <= 1'b0;
      load_q   <= 1'b0;
    end else begin
      width_q  <= width_d;
      height_q <= height_d;
      lt_q     <= lt_d;
      ctrl_q   <= ctrl_d;
      word_q   <= word_d;
      rdata_q  <= rdata_d;
      we_q     <= we_d;
      re_q     <= re_d;
      load_q   <= load_d;
    end
  end

  // sram strobes carry the address that was current before the advance
  logic [9:0]  acc_addr_q, acc_addr_d;
  logic [15:0] wdata_q,    wdata_d;

  always_comb begin
    acc_addr_d = acc_addr_q;
    wdata_d    = wdata_q;
    if (we_d || re_d) begin
      acc_addr_d = ctrl_q[9:0];
      wdata_d    = reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      acc_addr_q <= 10'h000;
      wdata_q    <= 16'h0000;
    end else begin
      acc_addr_q <= acc_addr_d;
      wdata_q    <= wdata_d;
    end
  end

  assign reg_rdata     = rdata_q;
  assign ram_addr      = acc_addr_q;
  assign ram_index     = ctrl_q[spoof_frame_pkg::RAM_IDX_LSB +: 3];
  assign ram_bank_luma = ctrl_q[spoof_frame_pkg::RAM_BANK_BIT];
  assign ram_wdata     = wdata_q;
  assign ram_we        = we_q;
  assign ram_re        = re_q;

  // spoof frame engine, shadow copies taken at frame start
  spoof_frame_pkg::spoof_state_t st_q, st_d;
  logic [7:0]        cnt_q,   cnt_d;
  logic [11:0]       bytes_q, bytes_d;
  logic [11:0]       lines_q, lines_d;
  logic [11:0]       sh_w_q,  sh_w_d;
  logic [11:0]       sh_h_q,  sh_h_d;
  logic [7:0]        sh_l_q,  sh_l_d;
  logic [7:0]        sh_t_q,  sh_t_d;
  logic [DATA_W-1:0] pd_q,    pd_d;
  logic              pv_q,    pv_d;
  logic              take;

  assign take = (st_q == spoof_frame_pkg::ST_LINE) && pix_clk_en && (bytes_q < sh_w_q);
  assign fifo_ready = take;

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    bytes_d = bytes_q;
    lines_d = lines_q;
    sh_w_d  = sh_w_q;
    sh_h_d  = sh_h_q;
    sh_l_d  = sh_l_q;
    sh_t_d  = sh_t_q;
    pd_d    = pd_q;
    pv_d    = 1'b0;
    if (pix_clk_en) begin
      case (st_q)
        spoof_frame_pkg::ST_IDLE: begin
          if (spoof_enable && fifo_valid && (height_q != 12'h000)) begin
            sh_w_d  = width_q;
            sh_h_d  = height_q;
            sh_l_d  = lt_q[spoof_frame_pkg::LEAD_LSB +: 8];
            sh_t_d  = lt_q[spoof_frame_pkg::TRAIL_LSB +: 8];
            cnt_d   = 8'h00;
            bytes_d = 12'h000;
            lines_d = 12'h000;
            st_d    = spoof_frame_pkg::ST_LEAD;
          end
        end
        spoof_frame_pkg::ST_LEAD: begin
          if (cnt_q + 8'h01 >= sh_l_q) begin
            cnt_d   = 8'h00;
            bytes_d = 12'h000;
            st_d    = spoof_frame_pkg::ST_LINE;
          end else begin
            cnt_d = cnt_q + 8'h01;
          end
        end
        spoof_frame_pkg::ST_LINE: begin
          if (take && fifo_valid) begin
            pd_d    = fifo_data;
            pv_d    = 1'b1;
            bytes_d = bytes_q + 12'h001;
            if (bytes_q + 12'h001 >= sh_w_q) begin
              st_d = spoof_frame_pkg::ST_TRAIL;
            end
          end else if (bytes_q >= sh_w_q) begin
            st_d = spoof_frame_pkg::ST_TRAIL;
          end
        end
        spoof_frame_pkg::ST_TRAIL: begin
          if (cnt_q + 8'h01 >= sh_t_q) begin
            cnt_d   = 8'h00;
            lines_d = lines_q + 12'h001;
            if (lines_q + 12'h001 >= sh_h_q) begin
              st_d = spoof_frame_pkg::ST_IDLE;
            end else begin
              st_d = spoof_frame_pkg::ST_LEAD;
            end
          end else begin
            cnt_d = cnt_q + 8'h01;
          end
        end
        default: st_d = spoof_frame_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      st_q    <= spoof_frame_pkg::ST_IDLE;
      cnt_q   <= 8'h00;
      bytes_q <= 12'h000;
      lines_q <= 12'h000;
      sh_w_q  <= spoof_frame_pkg::RST_LINE_WIDTH;
      sh_h_q  <= spoof_frame_pkg::RST_FRAME_HEIGHT;
      sh_l_q  <= spoof_frame_pkg::RST_LEAD_TRAIL[7:0];
      sh_t_q  <= spoof_frame_pkg::RST_LEAD_TRAIL[15:8];
      pd_q    <= '0;
      pv_q    <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      bytes_q <= bytes_d;
      lines_q <= lines_d;
      sh_w_q  <= sh_w_d;
      sh_h_q  <= sh_h_d;
      sh_l_q  <= sh_l_d;
      sh_t_q  <= sh_t_d;
      pd_q    <= pd_d;
      pv_q    <= pv_d;
    end
  end

  assign frame_valid    = (st_q != spoof_frame_pkg::ST_IDLE);
  assign line_valid     = (st_q == spoof_frame_pkg::ST_LINE);
  assign pix_data       = pd_q;
  assign pix_data_valid = pv_q;
endmodule : spoof_frame_timing_sram_test

// ---- testbench/spoof_frame_monitor.sv ----
// checker for spoof framing and sram test strobes
// assumes binding to the block top; pixel enable at most one per cycle
`timescale 1ns/1ns
module spoof_frame_monitor #(
  parameter int DATA_W = 8
) (
  input wire logic              ref_clk,
  input wire logic              reset_n,
  input wire logic [7:0]        reg_addr,
  input wire logic [15:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic              fifo_valid,
  input wire logic [DATA_W-1:0] fifo_data,
  input wire logic              fifo_ready,
  input wire logic              frame_valid,
  input wire logic              line_valid,
  input wire logic [DATA_W-1:0] pix_data,
  input wire logic              pix_data_valid,
  input wire logic [9:0]        ram_addr,
  input wire logic [15:0]       ram_wdata,
  input wire logic              ram_we,
  input wire logic              ram_re
);
  logic [9:0] last_q;
  logic       seen_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // last tested address, forgotten when software reloads it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      last_q <= 10'h000;
      seen_q <= 1'b0;
    end else if (reg_wr && reg_addr == spoof_frame_pkg::OFS_RAM_TEST_CTRL) begin
      seen_q <= 1'b0;
    end else if (ram_we || ram_re) begin
      last_q <= ram_addr;
      seen_q <= 1'b1;
    end
  end
  sequence s_quiet5;
    !line_valid [*5];
  endsequence
  property p_we_src;
    ram_we |-> $past(reg_wr && reg_addr == spoof_frame_pkg::OFS_INDIRECT_DATA);
  endproperty
  property p_wdata;
    ram_we |-> ram_wdata == $past(reg_wdata);
  endproperty
  property p_re_src;
    ram_re |-> $past(reg_rd && reg_addr == spoof_frame_pkg::OFS_INDIRECT_DATA);
  endproperty
  property p_step;
    (ram_we || ram_re) && seen_q |->
      ram_addr == ((last_q == 10'h31f) ? 10'h000 : last_q + 10'h001);
  endproperty
  property p_range;
    (ram_we || ram_re) |-> ram_addr <= 10'h31f;
  endproperty
  property p_in_frame;
    line_valid |-> frame_valid;
  endproperty
  property p_lead;
    $rose(frame_valid) |-> s_quiet5;
  endproperty
  property p_trail;
    $fell(line_valid) |-> s_quiet5;
  endproperty
  property p_byte;
    fifo_ready && fifo_valid |-> line_valid ##1 pix_data_valid && pix_data == $past(fifo_data);
  endproperty
  a_we_src: assert property (p_we_src) else $error("ram write without data write");
  a_wdata: assert property (p_wdata) else $error("ram write data wrong");
  a_re_src: assert property (p_re_src) else $error("ram read without data read");
  a_step: assert property (p_step) else $error("tested address did not step");
  a_range: assert property (p_range) else $error("tested address out of range");
  a_in_frame: assert property (p_in_frame) else $error("line outside frame");
  a_lead: assert property (p_lead) else $error("lead too short");
  a_trail: assert property (p_trail) else $error("trail too short");
  a_byte: assert property (p_byte) else $error("byte not passed on");
endmodule : spoof_frame_monitor
bind spoof_frame_timing_sram_test spoof_frame_monitor #(.DATA_W(DATA_W)) u_mon (
  .ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .fifo_valid, .fifo_data,
  .fifo_ready, .frame_valid, .line_valid, .pix_data, .pix_data_valid, .ram_addr,
  .ram_wdata, .ram_we, .ram_re);

// ---- testbench/pixel_receiver.sv ----
// host receiver model: counts lines and bytes of each spoof frame
// assumes strobes sampled on ref_clk
`timescale 1ns/1ns
module pixel_receiver (
  input  wire logic ref_clk,
  input  wire logic frame_valid,
  input  wire logic line_valid,
  input  wire logic pix_data_valid,
  output int        lines,
  output int        bytes,
  output int        frames
);
  int   lc = 0;
  int   bc = 0;
  logic fv_q = 1'b0;
  logic lv_q = 1'b0;
  always @(posedge ref_clk) begin
    fv_q <= frame_valid;
    lv_q <= line_valid;
    if (line_valid && !lv_q) lc <= lc + 1;
    if (pix_data_valid) bc <= bc + 1;
    if (!frame_valid && fv_q) begin
      lines  <= lc;
      bytes  <= bc;
      frames <= frames + 1;
      lc     <= 0;
      bc     <= 0;
    end
  end
endmodule : pixel_receiver

// ---- testbench/tb.sv ----
// self-checking bench: register reset values, spoof frame, sram test access
// assumes the receiver model on the pixel outputs
`timescale 1ns/1ns
module tb;
  logic ref_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, spoof_enable = 0;
  logic pix_clk_en = 0, fifo_valid = 1, fifo_ready, frame_valid, line_valid;
  logic pix_data_valid, ram_bank_luma, ram_we, ram_re;
  logic [7:0] reg_addr = 0, fifo_data = 0, pix_data;
  logic [15:0] reg_wdata = 0, reg_rdata, ram_wdata, ram_rdata = 0, v;
  logic [9:0] ram_addr;
  logic [2:0] ram_index;
  wire [15:0] ram_bus = {ram_re, ram_we, ram_bank_luma, ram_index, ram_addr};
  int fails = 0, checks = 0, lines, bytes, frames, i;
  logic [7:0] ra [5] = '{8'h10, 8'h11, 8'h12, 8'h1d, 8'h05};
  logic [15:0] rv [5] = '{16'h0640, 16'h0258, 16'h0606, 16'h0000, 16'h0000};
  logic [9:0] wa [3] = '{10'h31e, 10'h31f, 10'h000};
  logic [2:0] stall_q = 3'h0;
  spoof_frame_timing_sram_test DUT (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .spoof_enable, .pix_clk_en, .fifo_data, .fifo_valid, .fifo_ready,
    .frame_valid, .line_valid, .pix_data, .pix_data_valid, .ram_addr, .ram_index,
    .ram_bank_luma, .ram_wdata, .ram_we, .ram_re, .ram_rdata);
  pixel_receiver rx (.ref_clk, .frame_valid, .line_valid, .pix_data_valid, .lines,
    .bytes, .frames);
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    pix_clk_en <= ~pix_clk_en;
    // fifo runs dry one cycle in eight, always on an enable cycle
    stall_q <= stall_q + 3'h1;
    fifo_valid <= (stall_q != 3'h6);
    if (fifo_ready && fifo_valid) fifo_data <= fifo_data + 8'h01;
  end
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(negedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : rd
  task automatic end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    wr(8'h05, 16'hffff);
    for (i = 0; i < 5; i++) begin
      rd(ra[i], v);
      cmp("reset value", rv[i], v);
    end
    wr(8'h10, 16'h0004);
    wr(8'h11, 16'h0002);
    wr(8'h12, 16'h0505);
    @(posedge ref_clk);
    spoof_enable <= 1'b1;
    // drop the enable once a frame is under way so exactly one frame runs
    for (i = 0; i < 2000 && frames == 0; i++) begin
      @(posedge ref_clk);
      if (frame_valid) spoof_enable <= 1'b0;
    end
    cmp("frames", 16'h0001, 16'(frames));
    cmp("lines", 16'h0002, 16'(lines));
    cmp("bytes", 16'h0008, 16'(bytes));
    wr(8'h1d, 16'hb71e);
    for (i = 0; i < 3; i++) begin
      wr(8'h1f, 16'h1234 + 16'(i));
      cmp("sram write", {3'b011, 3'h5, wa[i]}, ram_bus);
      cmp("sram wdata", 16'h1234 + 16'(i), ram_wdata);
    end
    rd(8'h1d, v);
    cmp("ctrl", 16'hb401, v);
    wr(8'h1d, 16'h0005);
    @(posedge ref_clk);
    ram_rdata <= 16'hbeef;
    rd(8'h1f, v);
    cmp("sram read", {3'b100, 3'h0, 10'h005}, ram_bus);
    repeat (2) @(posedge ref_clk);
    rd(8'h1f, v);
    cmp("sram data", 16'hbeef, v);
    rd(8'h1d, v);
    cmp("ctrl", 16'h0007, v);
    end_sim();
  end
endmodule : tb
